// >>> rtl/bdcd_params.svh
/*
 Register indices, control-byte fields, bus decode positions and timing
 figures of the buffered change-detect I/O block.
 Assumes inclusion by bare name from package and design files.
*/
`ifndef BDCD_PARAMS_SVH
`define BDCD_PARAMS_SVH
// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define BD_IX_PA         2'h0
`define BD_IX_PB         2'h1
`define BD_IX_PC         2'h2
`define BD_IX_CTRL       2'h3
`define BD_IX_BUFEN0     5'h08
`define BD_IX_TRI        5'h0a
`define BD_IX_COSEN      5'h0b
`define BD_IX_CLR        5'h0f
`define BD_IX_CNT0       5'h10
`define BD_IX_STS        5'h1a
`define BD_IX_MSK        5'h1b
// ----------------------------------------
// Control byte fields, 1 = input
// ----------------------------------------
`define BD_CB_CLO        0
`define BD_CB_B          1
`define BD_CB_CHI        3
`define BD_CB_A          4
`define BD_CB_SET        7
`define BD_CTRL_RST      8'h9b
// ----------------------------------------
// Bus decode
// ----------------------------------------
`define BD_IX_LSB        2
`define BD_IX_MSB        6
`define BD_WIN_LSB       7
`define BD_WIN_MSB       11
`define BD_BASE_MIN      5'h08
`define BD_HSIZE_WORD    3'h2
// ----------------------------------------
// Timing and widths
// ----------------------------------------
`define BD_CLK_PERIOD_NS 5
`define BD_REF_PERIOD_NS 1000
`define BD_REF_DIV       (`BD_REF_PERIOD_NS / `BD_CLK_PERIOD_NS)
`define BD_PRESC_W       8
`define BD_CNT_W         16
`define BD_NUM_CNT       3
`endif

// >>> rtl/bdcd_pkg.sv
/*
 Types shared by the change-detect I/O block: bus phase, state record
 and counter load carrier.
 Assumes bdcd_params.svh on the include path.
*/
`include "bdcd_params.svh"
`default_nettype none
package bdcd_pkg;
	typedef enum logic [1:0] {ph_idle, ph_wr, ph_rd1, ph_rd2} bdcd_phase_e;

	typedef struct packed {
		logic                  ld;
		logic [`BD_CNT_W-1:0]  val;
	} bdcd_load_s;

	typedef struct packed {
		logic [47:0]            s1;
		logic [47:0]            s2;
		logic [47:0]            prev;
		logic [4:0]             base1;
		logic [4:0]             base2;
		logic [1:0]             ec1;
		logic [1:0]             ec2;
		logic [1:0]             ec3;
		bdcd_phase_e            ph;
		logic [4:0]             idx;
		logic                   hit;
		logic [31:0]            rdata;
		logic [1:0][7:0]        ctrl;
		logic [1:0][23:0]       olat;
		logic [1:0][7:0]        bufen;
		logic [1:0]             tri_on;
		logic [5:0]             cosen;
		logic [5:0]             sts;
		logic [5:0]             msk;
		logic [`BD_PRESC_W-1:0] presc;
		logic                   tick;
	} bdcd_state_s;

	typedef struct packed {
		logic [`BD_CNT_W-1:0] cnt;
	} bdcd_cnt_s;
endpackage
`default_nettype wire

// >>> rtl/bdcd_counter.sv
/*
 One 16-bit down counter of the optional counter section.
 Assumes a one-cycle count tick and load strobe from the same clock.
*/
`include "bdcd_params.svh"
`default_nettype none
module bdcd_counter
	import bdcd_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire bdcd_load_s       load,
	input  wire logic             tick,
	output logic [`BD_CNT_W-1:0]  count
);
	bdcd_cnt_s st_r;
	bdcd_cnt_s st_nxt;

	// ----------------------------------------
	// Count
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		// Load beats a tick in the same cycle
		if (load.ld) begin
			st_nxt.cnt = load.val;
		end else if (tick) begin
			st_nxt.cnt = st_r.cnt - `BD_CNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign count = st_r.cnt;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_cnt_step: assert property (tick && !load.ld |=> count == $past(count) - 16'h0001) else $error("counter did not step");
	a_cnt_load: assert property (load.ld |=> count == $past(load.val) ##1 ($past(tick) || $past(load.ld) || count == $past(load.val, 2))) else $error("counter load lost");
endmodule
`default_nettype wire

// >>> rtl/bdcd_top.sv
/*
 Buffered 48-line digital I/O with change-of-state interrupt, two port
 units of three 8-bit ports, buffer control and three down counters,
 as an AHB-Lite slave.
 Assumes hready is the bus ready fed back from hreadyout, line_in and
 counter clock pins are asynchronous, base_sel is a static strap.
*/
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`include "bdcd_params.svh"
`default_nettype none
// How it works
// - Enabled input changes set a sticky request
// - Six enable bits, one per port
// - Write to clear location drops request
// - Three 8-bit ports per unit, latched outputs
// - Port C nibbles take separate directions
// - Buffer direction follows unit control byte
// - Flag puts buffers under software enable
// - Decode 32-index window, base 400h-F80h
// - Second counter ticks from 1 MHz
// - Three independent 16-bit counters
// - Reset makes every line an input
// - Switching to output zeroes the latch
// - Flags are bit 0 and bit 1
module bdcd_top
	import bdcd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic [47:0] line_in,
	output logic [47:0]      line_out,
	output logic [47:0]      line_oe,
	input  wire logic [4:0]  base_sel,
	input  wire logic [1:0]  cnt_clk_in,
	output logic             irq
);
	bdcd_state_s st_r;
	bdcd_state_s st_nxt;

	logic                                acc;
	logic                                addr_hit;
	logic                                wr_en;
	logic [5:0]                          clr_sts;
	logic [5:0]                          port_chg;
	logic [47:0]                         chg;
	logic [1:0][23:0]                    dout;
	logic [1:0][23:0]                    oe;
	logic [1:0][23:0]                    rd_lines;
	logic [1:0]                          ec_fall;
	logic [`BD_NUM_CNT-1:0]              ctick;
	bdcd_load_s [`BD_NUM_CNT-1:0]        ld;
	logic [`BD_NUM_CNT-1:0][`BD_CNT_W-1:0] cnt_q;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic [4:0] idx_of(input logic u, input logic [1:0] p);
		return {2'h0, u, p};
	endfunction

	// Flags ordered {C hi, C lo, B, A} spread to the 24 lines
	function automatic logic [23:0] lanes(input logic [3:0] f);
		return {{4{f[3]}}, {4{f[2]}}, {8{f[1]}}, {8{f[0]}}};
	endfunction

	function automatic logic [23:0] out_lanes(input logic [7:0] c);
		return lanes(~{c[`BD_CB_CHI], c[`BD_CB_CLO], c[`BD_CB_B], c[`BD_CB_A]});
	endfunction

	// ----------------------------------------
	// Line direction, buffers, change detect
	// ----------------------------------------
	genvar gu;
	genvar gk;
	generate
		for (gu = 0; gu < 2; gu++) begin : g_unit
			assign dout[gu] = out_lanes(st_r.ctrl[gu]);
			// Program control only narrows what direction allows
			assign oe[gu] = dout[gu] & (st_r.tri_on[gu] ? lanes(st_r.bufen[gu][3:0]) : '1);
			assign rd_lines[gu] = (st_r.s2[gu*24 +: 24] & ~dout[gu]) |
				(st_r.olat[gu] & dout[gu]);
		end
		for (gk = 0; gk < 6; gk++) begin : g_port
			assign port_chg[gk] = (|chg[gk*8 +: 8]) & st_r.cosen[gk];
		end
	endgenerate

	// Output lines never count as changes
	assign chg = (st_r.s2 ^ st_r.prev) & ~dout;
	assign line_oe = oe;
	assign line_out = st_r.olat;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	assign acc = hsel && htrans[1] && hready;
	assign addr_hit = (haddr[`BD_WIN_MSB:`BD_WIN_LSB] == st_r.base2) &&
		(st_r.base2 >= `BD_BASE_MIN) && (haddr[31:`BD_WIN_MSB+1] == '0) &&
		(hsize == `BD_HSIZE_WORD);
	assign wr_en = (st_r.ph == ph_wr) && st_r.hit;
	assign hreadyout = (st_r.ph != ph_rd1);
	assign hrdata = st_r.rdata;
	assign hresp = 1'b0;

	always_comb begin
		clr_sts = '0;
		if (wr_en && st_r.idx == `BD_IX_CLR) begin
			clr_sts = '1;
		end else if (wr_en && st_r.idx == `BD_IX_STS) begin
			clr_sts = hwdata[5:0];
		end
	end

	// ----------------------------------------
	// Counters
	// ----------------------------------------
	assign ec_fall = st_r.ec3 & ~st_r.ec2;
	assign ctick = {ec_fall[1], st_r.tick, ec_fall[0]};

	generate
		for (gk = 0; gk < `BD_NUM_CNT; gk++) begin : g_cnt
			assign ld[gk].ld = wr_en && (st_r.idx == `BD_IX_CNT0 + 5'(gk));
			assign ld[gk].val = hwdata[`BD_CNT_W-1:0];
			bdcd_counter u_cnt (
				.clk   (clk),
				.nrst  (nrst),
				.load  (ld[gk]),
				.tick  (ctick[gk]),
				.count (cnt_q[gk])
			);
		end
	endgenerate

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [31:0] rv;
		rv = '0;
		st_nxt = st_r;
		st_nxt.s1 = line_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.prev = st_r.s2;
		st_nxt.base1 = base_sel;
		st_nxt.base2 = st_r.base1;
		st_nxt.ec1 = cnt_clk_in;
		st_nxt.ec2 = st_r.ec1;
		st_nxt.ec3 = st_r.ec2;
		st_nxt.tick = (st_r.presc == `BD_PRESC_W'(`BD_REF_DIV - 1));
		st_nxt.presc = st_nxt.tick ? '0 : st_r.presc + `BD_PRESC_W'(1);

		// Read mux
		for (int u = 0; u < 2; u++) begin
			if (st_r.idx == idx_of(u[0], `BD_IX_PA)) rv[7:0] = rd_lines[u][7:0];
			if (st_r.idx == idx_of(u[0], `BD_IX_PB)) rv[7:0] = rd_lines[u][15:8];
			if (st_r.idx == idx_of(u[0], `BD_IX_PC)) rv[7:0] = rd_lines[u][23:16];
		end
		for (int i = 0; i < `BD_NUM_CNT; i++) begin
			if (st_r.idx == `BD_IX_CNT0 + 5'(i)) rv[`BD_CNT_W-1:0] = cnt_q[i];
		end
		if (st_r.idx == `BD_IX_TRI) rv[1:0] = st_r.tri_on;
		if (st_r.idx == `BD_IX_COSEN) rv[5:0] = st_r.cosen;
		if (st_r.idx == `BD_IX_STS) rv[5:0] = st_r.sts;
		if (st_r.idx == `BD_IX_MSK) rv[5:0] = st_r.msk;
		if (!st_r.hit) rv = '0;

		// One wait state on reads keeps hrdata registered
		unique case (st_r.ph)
			ph_rd1: begin
				st_nxt.rdata = rv;
				st_nxt.ph = ph_rd2;
			end
			ph_idle, ph_wr, ph_rd2: begin
				st_nxt.ph = acc ? (hwrite ? ph_wr : ph_rd1) : ph_idle;
				if (acc) begin
					st_nxt.idx = haddr[`BD_IX_MSB:`BD_IX_LSB];
					st_nxt.hit = addr_hit;
				end
			end
		endcase

		// Register writes
		if (wr_en) begin
			for (int u = 0; u < 2; u++) begin
				if (st_r.idx == idx_of(u[0], `BD_IX_PA)) st_nxt.olat[u][7:0] = hwdata[7:0];
				if (st_r.idx == idx_of(u[0], `BD_IX_PB)) st_nxt.olat[u][15:8] = hwdata[7:0];
				if (st_r.idx == idx_of(u[0], `BD_IX_PC)) st_nxt.olat[u][23:16] = hwdata[7:0];
				// Bit-set form of the control byte is not supported
				if (st_r.idx == idx_of(u[0], `BD_IX_CTRL) && hwdata[`BD_CB_SET]) begin
					st_nxt.ctrl[u] = hwdata[7:0];
					st_nxt.olat[u] = st_nxt.olat[u] & ~out_lanes(hwdata[7:0]);
				end
				if (st_r.idx == `BD_IX_BUFEN0 + 5'(u)) st_nxt.bufen[u] = hwdata[7:0];
			end
			if (st_r.idx == `BD_IX_TRI) st_nxt.tri_on = hwdata[1:0];
			if (st_r.idx == `BD_IX_COSEN) st_nxt.cosen = hwdata[5:0];
			if (st_r.idx == `BD_IX_MSK) st_nxt.msk = hwdata[5:0];
		end

		// New change beats a clear in the same cycle
		st_nxt.sts = (st_r.sts & ~clr_sts) | port_chg;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_r <= '0;
			st_r.ctrl <= {2{`BD_CTRL_RST}};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign irq = |(st_r.sts & st_r.msk);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	sequence s_rd_req;
		acc && !hwrite;
	endsequence

	sequence s_rd_wait;
		!hreadyout ##1 hreadyout;
	endsequence

	sequence s_ctrl0_wr;
		wr_en && st_r.idx == idx_of(1'b0, `BD_IX_CTRL) && hwdata[`BD_CB_SET];
	endsequence

	a_cos_set: assert property (|port_chg |=> (st_r.sts & $past(port_chg)) == $past(port_chg)) else $error("change not latched");
	a_cos_hold: assert property (clr_sts == '0 |=> (st_r.sts & $past(st_r.sts)) == $past(st_r.sts)) else $error("request dropped");
	a_cos_gate: assert property ($rose(st_r.sts[0]) |-> $past(st_r.cosen[0])) else $error("disabled port latched");
	a_cos_clear: assert property (wr_en && st_r.idx == `BD_IX_CLR && port_chg == '0 |=> st_r.sts == '0) else $error("clear write ignored");
	a_rst_input: assert property (@(posedge clk) disable iff (1'b0) !nrst |=> line_oe == '0) else $error("line driven after reset");
	a_dir_follow: assert property (s_ctrl0_wr ##0 !st_r.tri_on[0] |=> line_oe[23:0] == out_lanes($past(hwdata[7:0]))) else $error("buffer direction wrong");
	a_nib_split: assert property (s_ctrl0_wr ##0 !st_r.tri_on[0] && hwdata[`BD_CB_CHI] && !hwdata[`BD_CB_CLO] |=> line_oe[23:16] == 8'h0f) else $error("port C split wrong");
	a_tri_force: assert property (st_r.tri_on[0] && st_r.bufen[0][3:0] == 4'h0 |-> line_oe[23:0] == '0) else $error("buffer not forced off");
	a_tri_bits: assert property (wr_en && st_r.idx == `BD_IX_TRI |=> st_r.tri_on == $past(hwdata[1:0])) else $error("flag bits misplaced");
	a_latch_clr: assert property (s_ctrl0_wr ##0 !hwdata[`BD_CB_A] |=> line_out[7:0] == 8'h00) else $error("output latch not zeroed");
	a_ref_tick: assert property (st_r.tick |=> (!st_r.tick [*8]) ##192 st_r.tick) else $error("reference tick rate wrong");
	a_unmapped: assert property (s_rd_req ##0 !addr_hit |=> s_rd_wait ##0 hrdata == '0) else $error("unmapped read not zero");
endmodule
`default_nettype wire

// >>> dv/bdcd_field.sv
/*
 Field equipment on the 48 I/O lines: drives the lanes the bench enables.
 Assumes pull-ups on every line and that the block wins where it drives.
*/
`default_nettype none
module bdcd_field (
	input  wire logic [47:0] line_out,
	input  wire logic [47:0] line_oe,
	input  wire logic [47:0] fdrv,
	input  wire logic [47:0] fen,
	output logic      [47:0] line_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Undriven lines float high on the pull-ups, never hold an old value
	assign line_in = (line_oe & line_out) | (~line_oe & ((fen & fdrv) | ~fen));
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
/*
 Self-checking bench for the change-detect I/O block over AHB-Lite.
 Assumes the block's hreadyout is fed back as hready, strap fixed at 400h.
*/
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [4:0] BASE = 5'h08;
	logic        clk, nrst, hsel, hwrite, hreadyout, hresp, irq;
	logic [1:0]  htrans, cnt_clk;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [47:0] line_in, line_out, line_oe, fdrv, fen;
	int          error_cnt, samples_checked;

	bdcd_top u_dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .line_in(line_in),
		.line_out(line_out), .line_oe(line_oe), .base_sel(BASE), .cnt_clk_in(cnt_clk),
		.irq(irq));
	bdcd_field u_field (.line_out(line_out), .line_oe(line_oe), .fdrv(fdrv), .fen(fen),
		.line_in(line_in));

	always #2.5 clk = ~clk;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Entered at a rising edge; ready and read data are taken at rising edges only
	task automatic bus(input logic w, input logic [4:0] b, input logic [4:0] ix,
		input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {20'h0, b, ix, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// One more edge so that outputs already show the write when looked at
	task automatic wr(input logic [4:0] ix, input logic [31:0] wd);
		bus(1'b1, BASE, ix, wd);
		@(posedge clk);
	endtask

	task automatic rdc(input string nm, input logic [4:0] ix, input logic [15:0] exp);
		bus(1'b0, BASE, ix, 32'h0);
		chk(nm, {32'h0, rd[15:0]}, {32'h0, exp});
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		cnt_clk = 2'b00;
		fdrv = 48'h0000_0000_003c;
		fen = 48'h0000_0000_00ff;
		error_cnt = 0;
		samples_checked = 0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		cyc(4);
		chk("oe_rst", line_oe, 48'h0);
		chk("out_rst", line_out, 48'h0);
		chk("irq_rst", {47'h0, irq}, 48'h0);
		rdc("pa0_in", 5'h00, 16'h003c);
		rdc("pb0_pull", 5'h01, 16'h00ff);
		// Latch written while input must be zeroed by the switch to output
		wr(5'h00, 32'ha5);
		wr(5'h03, 32'h80);
		chk("oe_out", {24'h0, line_oe[23:0]}, 48'hff_ffff);
		rdc("pa0_zero", 5'h00, 16'h0000);
		wr(5'h00, 32'ha5);
		rdc("pa0_latch", 5'h00, 16'h00a5);
		chk("out_a", {40'h0, line_out[7:0]}, 48'ha5);
		rdc("ctrl_wo", 5'h03, 16'h0000);
		wr(5'h03, 32'h88);
		chk("oe_split_hi", {24'h0, line_oe[23:0]}, 48'h0f_ffff);
		wr(5'h03, 32'h81);
		chk("oe_split", {24'h0, line_oe[23:0]}, 48'hf0_ffff);
		wr(5'h0a, 32'h1);
		chk("oe_off", {24'h0, line_oe[23:0]}, 48'h0);
		wr(5'h08, 32'h1);
		chk("oe_prog", {24'h0, line_oe[23:0]}, 48'h00_00ff);
		rdc("tri_rd", 5'h0a, 16'h0001);
		wr(5'h0a, 32'h0);
		chk("oe_auto", {24'h0, line_oe[23:0]}, 48'hf0_ffff);
		// Change of state enabled on unit 1 port A only
		wr(5'h0b, 32'h08);
		wr(5'h1b, 32'h3f);
		fdrv[24] <= 1'b0;
		fen[24] <= 1'b1;
		cyc(8);
		rdc("sts_set", 5'h1a, 16'h0008);
		chk("irq_on", {47'h0, irq}, 48'h1);
		wr(5'h1b, 32'h0);
		chk("irq_mask", {47'h0, irq}, 48'h0);
		wr(5'h1b, 32'h3f);
		rdc("sts_hold", 5'h1a, 16'h0008);
		wr(5'h0f, 32'h0);
		rdc("sts_clr", 5'h1a, 16'h0000);
		chk("irq_off", {47'h0, irq}, 48'h0);
		fen[32] <= 1'b1;
		cyc(8);
		rdc("sts_dis", 5'h1a, 16'h0000);
		fen[24] <= 1'b0;
		cyc(8);
		rdc("sts_back", 5'h1a, 16'h0008);
		wr(5'h1a, 32'h08);
		rdc("sts_w1c", 5'h1a, 16'h0000);
		// Decode: other window and unmapped index
		bus(1'b1, 5'h09, 5'h0b, 32'h3f);
		rdc("win", 5'h0b, 16'h0008);
		bus(1'b0, 5'h09, 5'h0b, 32'h0);
		chk("win_rd", {16'h0, rd}, 48'h0);
		chk("hresp", {47'h0, hresp}, 48'h0);
		rdc("unmap", 5'h13, 16'h0000);
		// Counters: three pulses on 0, two on 2, reference on 1
		wr(5'h10, 32'h0010);
		wr(5'h12, 32'h0020);
		for (int i = 0; i < 3; i++) begin
			cnt_clk <= {i < 2, 1'b1};
			cyc(4);
			cnt_clk <= 2'b00;
			cyc(4);
		end
		cyc(4);
		rdc("cnt0", 5'h10, 16'h000d);
		rdc("cnt2", 5'h12, 16'h001e);
		wr(5'h11, 32'h0100);
		cyc(2000);
		bus(1'b0, BASE, 5'h11, 32'h0);
		// Tick phase against the load is free, so two ticks of slack
		chk("cnt1", {47'h0, rd[15:0] >= 16'h00f4 && rd[15:0] <= 16'h00f6}, 48'h1);
		end_of_test();
	end
endmodule
`default_nettype wire
